// >>> rtl/spm_master.sv
// SPI master with RAM-direct buffers and a classic Wishbone register slave
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "spm_consts.svh"

module spm_master (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // RAM port
  output var  logic        mem_req_o,
  output var  logic        mem_we_o,
  output var  logic [31:0] mem_addr_o,
  output var  logic [7:0]  mem_wdata_o,
  input  wire logic [7:0]  mem_rdata_i,
  input  wire logic        mem_ack_i,
  // SPI pins
  output var  logic        sck_o,
  output var  logic        mosi_o,
  input  wire logic        miso_i,
  output var  logic        csn_o
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [8:0] rate_half(input logic [31:0] code);
    case (code)
      `SPM_R_K125: rate_half = `SPM_H_K125;
      `SPM_R_K250: rate_half = `SPM_H_K250;
      `SPM_R_K500: rate_half = `SPM_H_K500;
      `SPM_R_M1:   rate_half = `SPM_H_M1;
      `SPM_R_M2:   rate_half = `SPM_H_M2;
      `SPM_R_M4:   rate_half = `SPM_H_M4;
      `SPM_R_M8:   rate_half = `SPM_H_M8;
      `SPM_R_M16:  rate_half = `SPM_H_FAST;
      `SPM_R_M32:  rate_half = `SPM_H_FAST;
      default:     rate_half = `SPM_H_K250;
    endcase
  endfunction : rate_half

  function automatic logic [15:0] umin16(input logic [15:0] a, input logic [15:0] b);
    umin16 = (a < b) ? a : b;
  endfunction : umin16

  function automatic logic out_bit(input logic [7:0] sh, input logic lsb);
    out_bit = lsb ? sh[0] : sh[7];
  endfunction : out_bit

  function automatic logic [7:0] adv(input logic [7:0] sh, input logic lsb);
    adv = lsb ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
  endfunction : adv

  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b, input logic lsb);
    shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction : shift_in

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  spm_pkg::spm_regs_t s;
  spm_pkg::spm_regs_t n;
  logic [31:0]        rd;
  logic [31:0]        wv;
  logic               req;
  logic               wr;
  logic               start;
  logic               fin;
  logic               lead;
  logic               lsb;
  logic               cpha;
  logic [15:0]        nidx;

  always_comb begin
    n     = s;
    rd    = 32'h0;
    start = 1'b0;
    fin   = 1'b0;
    lead  = 1'b0;
    lsb   = s.fmt[`SPM_FMT_LSB];
    cpha  = s.fmt[`SPM_FMT_CPHA];
    nidx  = s.idx + 16'h1;
    n.miso_m = miso_i;
    n.miso_s = s.miso_m;
    req   = wb_cyc_i & wb_stb_i & ~s.ack;
    wr    = req & wb_we_i;
    n.ack = req;

    // ------------------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------------------
    case (wb_adr_i)
      `SPM_A_EV_ENDRX:  rd = {31'h0, s.evts[`SPM_EV_ENDRX]};
      `SPM_A_EV_END:    rd = {31'h0, s.evts[`SPM_EV_END]};
      `SPM_A_EV_TX_BUFFER_DONE_EVENT:  rd = {31'h0, s.evts[`SPM_EV_TX_BUFFER_DONE_EVENT]};
      `SPM_A_SHORTS:    rd = {31'h0, s.shorts};
      `SPM_A_INTENSET:  rd = {29'h0, s.inten};
      `SPM_A_IRQ_DISABLE_REG:  rd = {29'h0, s.inten};
      `SPM_A_STALL:     rd = {30'h0, s.stall};
      `SPM_A_ENABLE:    rd = {28'h0, s.en};
      `SPM_A_PSEL_SCK:  rd = s.psel_sck;
      `SPM_A_PSEL_MOSI: rd = s.psel_mosi;
      `SPM_A_PSEL_MISO: rd = s.psel_miso;
      `SPM_A_CHIP_SELECT_PIN_SELECT:  rd = s.chip_select_pin_select;
      `SPM_A_RATE:      rd = s.rate;
      `SPM_A_RX_PTR:    rd = s.rx_ptr;
      `SPM_A_RX_CNT:    rd = {16'h0, s.rx_cnt};
      `SPM_A_RX_DONE:   rd = {16'h0, s.rx_done};
      `SPM_A_RX_LIST:   rd = {30'h0, s.rx_list};
      `SPM_A_TX_PTR:    rd = s.tx_ptr;
      `SPM_A_TX_CNT:    rd = {16'h0, s.tx_cnt};
      `SPM_A_TX_DONE:   rd = {16'h0, s.tx_done};
      `SPM_A_TX_LIST:   rd = {30'h0, s.tx_list};
      `SPM_A_FORMAT:    rd = {29'h0, s.fmt};
      `SPM_A_RXDELAY:   rd = {29'h0, s.rxdly};
      `SPM_A_CSNDUR:    rd = {24'h0, s.csndur};
      `SPM_A_SELECT_POLARITY:    rd = {31'h0, s.pol};
      `SPM_A_DCX_PSEL:  rd = s.dcx_psel;
      `SPM_A_DCX_CNT:   rd = {28'h0, s.dcx_cnt};
      `SPM_A_FILLER:    rd = {24'h0, s.filler};
      default:          rd = 32'h0;
    endcase
    n.rdat = req ? rd : 32'h0;
    for (int i = 0; i < 4; i++) begin
      wv[i*8 +: 8] = wb_sel_i[i] ? wb_dat_i[i*8 +: 8] : rd[i*8 +: 8];
    end

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    if (wr) begin
      case (wb_adr_i)
        `SPM_A_START:     start = wv[0];
        `SPM_A_SUSPEND:   n.susp = s.susp | wv[0];
        `SPM_A_RESUME:    n.susp = s.susp & ~wv[0];
        `SPM_A_EV_ENDRX:  n.evts[`SPM_EV_ENDRX] = wv[0];
        `SPM_A_EV_END:    n.evts[`SPM_EV_END] = wv[0];
        `SPM_A_EV_TX_BUFFER_DONE_EVENT:  n.evts[`SPM_EV_TX_BUFFER_DONE_EVENT] = wv[0];
        `SPM_A_SHORTS:    n.shorts = wv[0];
        `SPM_A_INTENSET:  n.inten = s.inten | wv[2:0];
        `SPM_A_IRQ_DISABLE_REG:  n.inten = s.inten & ~wv[2:0];
        `SPM_A_STALL:     n.stall = wv[1:0];
        `SPM_A_ENABLE:    n.en = wv[3:0];
        `SPM_A_PSEL_SCK:  n.psel_sck = wv;
        `SPM_A_PSEL_MOSI: n.psel_mosi = wv;
        `SPM_A_PSEL_MISO: n.psel_miso = wv;
        `SPM_A_CHIP_SELECT_PIN_SELECT:  n.chip_select_pin_select = wv;
        `SPM_A_RATE:      n.rate = wv;
        `SPM_A_RX_PTR:    n.rx_ptr = wv;
        `SPM_A_RX_CNT:    n.rx_cnt = wv[15:0];
        `SPM_A_RX_LIST:   n.rx_list = wv[1:0];
        `SPM_A_TX_PTR:    n.tx_ptr = wv;
        `SPM_A_TX_CNT:    n.tx_cnt = wv[15:0];
        `SPM_A_TX_LIST:   n.tx_list = wv[1:0];
        `SPM_A_FORMAT:    n.fmt = wv[2:0];
        `SPM_A_RXDELAY:   n.rxdly = wv[2:0];
        `SPM_A_CSNDUR:    n.csndur = wv[7:0];
        `SPM_A_SELECT_POLARITY:    n.pol = wv[0];
        `SPM_A_DCX_PSEL:  n.dcx_psel = wv;
        `SPM_A_DCX_CNT:   n.dcx_cnt = wv[3:0];
        `SPM_A_FILLER:    n.filler = wv[7:0];
        default: ;
      endcase
    end

    // ------------------------------------------------------------------------
    // Delayed MISO capture
    // ------------------------------------------------------------------------
    if (s.pend) begin
      if (s.dcnt == 3'h1) begin
        n.pend = 1'b0;
        n.rxsh = shift_in(s.rxsh, s.miso_s, lsb);
      end else begin
        n.dcnt = s.dcnt - 3'h1;
      end
    end

    // ------------------------------------------------------------------------
    // Transaction sequencer
    // ------------------------------------------------------------------------
    unique case (s.st)
      spm_pkg::ST_IDLE: begin
        n.sck = s.fmt[`SPM_FMT_CPOL];
        n.csn = ~s.pol;
        if (start && s.en == `SPM_ENABLE_ON) begin
          n.idx   = 16'h0;
          n.total = (s.rx_cnt > s.tx_cnt) ? s.rx_cnt : s.tx_cnt;
          n.cnt   = `SPM_START_CYC;
          n.st    = spm_pkg::ST_WAKE;
        end
      end
      spm_pkg::ST_WAKE: begin
        if (s.cnt != 16'h0) begin
          n.cnt = s.cnt - 16'h1;
        end else if (s.total == 16'h0) begin
          fin = 1'b1;
        end else begin
          n.csn = s.pol;
          n.cnt = {8'h0, s.csndur};
          n.st  = spm_pkg::ST_LEAD;
        end
      end
      spm_pkg::ST_LEAD: begin
        if (s.cnt != 16'h0) begin
          n.cnt = s.cnt - 16'h1;
        end else begin
          n.st = spm_pkg::ST_FETCH;
        end
      end
      spm_pkg::ST_FETCH: begin
        if (s.idx >= s.tx_cnt && !s.susp) begin
          n.txsh   = s.filler;
          n.mosi   = cpha ? s.mosi : out_bit(s.filler, lsb);
          n.div    = rate_half(s.rate) - 9'h1;
          n.edge_n = 4'h0;
          n.st     = spm_pkg::ST_SHIFT;
        end else if (s.idx < s.tx_cnt) begin
          if (s.mem_req && mem_ack_i) begin
            n.mem_req = 1'b0;
            n.txsh    = mem_rdata_i;
            n.mosi    = cpha ? s.mosi : out_bit(mem_rdata_i, lsb);
            n.div     = rate_half(s.rate) - 9'h1;
            n.edge_n  = 4'h0;
            n.st      = spm_pkg::ST_SHIFT;
          end else if (s.mem_req) begin
            n.stall[`SPM_STALL_TX] = 1'b1;
          end else if (!s.susp) begin
            n.mem_req  = 1'b1;
            n.mem_we   = 1'b0;
            n.mem_addr = s.tx_ptr + {16'h0, s.idx};
          end
        end
      end
      spm_pkg::ST_SHIFT: begin
        if (s.div != 9'h0) begin
          n.div = s.div - 9'h1;
        end else begin
          n.div = rate_half(s.rate) - 9'h1;
          n.sck = ~s.sck;
          lead  = ~s.edge_n[0];
          if (lead ^ cpha) begin
            if (s.rxdly == 3'h0) begin
              n.rxsh = shift_in(s.rxsh, s.miso_s, lsb);
            end else begin
              n.pend = 1'b1;
              n.dcnt = s.rxdly;
            end
          end else if (cpha && s.edge_n == 4'h0) begin
            n.mosi = out_bit(s.txsh, lsb);
          end else if (s.edge_n != `SPM_LAST_EDGE) begin
            n.txsh = adv(s.txsh, lsb);
            n.mosi = out_bit(adv(s.txsh, lsb), lsb);
          end
          if (s.edge_n == `SPM_LAST_EDGE) begin
            n.st = spm_pkg::ST_DRAIN;
          end else begin
            n.edge_n = s.edge_n + 4'h1;
          end
        end
      end
      spm_pkg::ST_DRAIN: begin
        if (!s.pend) begin
          if (s.idx < s.rx_cnt) begin
            n.st = spm_pkg::ST_STORE;
          end else begin
            n.idx = nidx;
            n.st  = (nidx == s.total) ? spm_pkg::ST_TRAIL : spm_pkg::ST_FETCH;
            n.cnt = {8'h0, s.csndur};
          end
        end
      end
      spm_pkg::ST_STORE: begin
        if (s.mem_req && mem_ack_i) begin
          n.mem_req = 1'b0;
          n.mem_we  = 1'b0;
          n.idx     = nidx;
          n.st      = (nidx == s.total) ? spm_pkg::ST_TRAIL : spm_pkg::ST_FETCH;
          n.cnt     = {8'h0, s.csndur};
        end else if (s.mem_req) begin
          n.stall[`SPM_STALL_RX] = 1'b1;
        end else begin
          n.mem_req  = 1'b1;
          n.mem_we   = 1'b1;
          n.mem_addr = s.rx_ptr + {16'h0, s.idx};
          n.mem_wdat = s.rxsh;
        end
      end
      spm_pkg::ST_TRAIL: begin
        if (s.cnt != 16'h0) begin
          n.cnt = s.cnt - 16'h1;
        end else begin
          fin = 1'b1;
        end
      end
      spm_pkg::ST_GAP: begin
        if (s.cnt != 16'h0) begin
          n.cnt = s.cnt - 16'h1;
        end else begin
          n.idx   = 16'h0;
          n.total = (s.rx_cnt > s.tx_cnt) ? s.rx_cnt : s.tx_cnt;
          n.cnt   = 16'h0;
          n.st    = spm_pkg::ST_WAKE;
        end
      end
    endcase

    // ------------------------------------------------------------------------
    // Stop and transaction end
    // ------------------------------------------------------------------------
    if (wr && wb_adr_i == `SPM_A_STOP && wv[0] && s.st != spm_pkg::ST_IDLE) begin
      n.mem_req = 1'b0;
      n.mem_we  = 1'b0;
      n.pend    = 1'b0;
      n.csn     = ~s.pol;
      n.st      = spm_pkg::ST_IDLE;
      n.susp    = 1'b0;
      n.tx_done = umin16(s.idx, s.tx_cnt);
      n.rx_done = umin16(s.idx, s.rx_cnt);
    end else if (fin) begin
      n.csn     = ~s.pol;
      n.tx_done = umin16(s.total, s.tx_cnt);
      n.rx_done = umin16(s.total, s.rx_cnt);
      n.evts    = 3'h7;
      if (s.tx_list == `SPM_LIST_ARRAY) begin
        n.tx_ptr = s.tx_ptr + {16'h0, s.tx_cnt};
      end
      if (s.rx_list == `SPM_LIST_ARRAY) begin
        n.rx_ptr = s.rx_ptr + {16'h0, s.rx_cnt};
      end
      n.cnt = {8'h0, s.csndur};
      n.st  = s.shorts ? spm_pkg::ST_GAP : spm_pkg::ST_IDLE;
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s           <= '0;
      s.st        <= spm_pkg::ST_IDLE;
      s.rate      <= `SPM_RATE_RST;
      s.psel_sck  <= `SPM_PSEL_RST;
      s.psel_mosi <= `SPM_PSEL_RST;
      s.psel_miso <= `SPM_PSEL_RST;
      s.chip_select_pin_select  <= `SPM_PSEL_RST;
      s.dcx_psel  <= `SPM_PSEL_RST;
      s.csn       <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign wb_dat_o    = s.rdat;
  assign wb_ack_o    = s.ack;
  assign mem_req_o   = s.mem_req;
  assign mem_we_o    = s.mem_we;
  assign mem_addr_o  = s.mem_addr;
  assign mem_wdata_o = s.mem_wdat;
  assign sck_o       = s.sck;
  assign mosi_o      = s.mosi;
  assign csn_o       = s.csn;

endmodule : spm_master

`default_nettype wire

// >>> rtl/spm_consts.svh
// Register offsets, field positions, reset values and timing counts of the SPI master
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define SPM_A_START      12'h010
`define SPM_A_STOP       12'h014
`define SPM_A_SUSPEND    12'h01c
`define SPM_A_RESUME     12'h020
`define SPM_A_EV_ENDRX   12'h110
`define SPM_A_EV_END     12'h118
`define SPM_A_EV_TX_BUFFER_DONE_EVENT   12'h120
`define SPM_A_SHORTS     12'h200
`define SPM_A_INTENSET   12'h304
`define SPM_A_IRQ_DISABLE_REG   12'h308
`define SPM_A_STALL      12'h400
`define SPM_A_ENABLE     12'h500
`define SPM_A_PSEL_SCK   12'h508
`define SPM_A_PSEL_MOSI  12'h50c
`define SPM_A_PSEL_MISO  12'h510
`define SPM_A_CHIP_SELECT_PIN_SELECT   12'h514
`define SPM_A_RATE       12'h524
`define SPM_A_RX_PTR     12'h534
`define SPM_A_RX_CNT     12'h538
`define SPM_A_RX_DONE    12'h53c
`define SPM_A_RX_LIST    12'h540
`define SPM_A_TX_PTR     12'h544
`define SPM_A_TX_CNT     12'h548
`define SPM_A_TX_DONE    12'h54c
`define SPM_A_TX_LIST    12'h550
`define SPM_A_FORMAT     12'h554
`define SPM_A_RXDELAY    12'h560
`define SPM_A_CSNDUR     12'h564
`define SPM_A_SELECT_POLARITY     12'h568
`define SPM_A_DCX_PSEL   12'h56c
`define SPM_A_DCX_CNT    12'h570
`define SPM_A_FILLER     12'h5c0

// ----------------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------------
`define SPM_STALL_TX     0
`define SPM_STALL_RX     1
`define SPM_FMT_LSB      0
`define SPM_FMT_CPHA     1
`define SPM_FMT_CPOL     2
`define SPM_EV_END       0
`define SPM_EV_TX_BUFFER_DONE_EVENT     1
`define SPM_EV_ENDRX     2
`define SPM_LIST_ARRAY   2'h1
`define SPM_ENABLE_ON    4'h7

// ----------------------------------------------------------------------------
// Reset values and bit-rate codes
// ----------------------------------------------------------------------------
`define SPM_RATE_RST     32'h04000000
`define SPM_PSEL_RST     32'hffffffff
`define SPM_R_K125       32'h02000000
`define SPM_R_K250       32'h04000000
`define SPM_R_K500       32'h08000000
`define SPM_R_M1         32'h10000000
`define SPM_R_M2         32'h20000000
`define SPM_R_M4         32'h40000000
`define SPM_R_M8         32'h80000000
`define SPM_R_M16        32'h0a000000
`define SPM_R_M32        32'h14000000

// ----------------------------------------------------------------------------
// Half SCK periods in clk cycles at 40 MHz
// ----------------------------------------------------------------------------
`define SPM_H_K125       9'h0a0
`define SPM_H_K250       9'h050
`define SPM_H_K500       9'h028
`define SPM_H_M1         9'h014
`define SPM_H_M2         9'h00a
`define SPM_H_M4         9'h005
`define SPM_H_M8         9'h002
`define SPM_H_FAST       9'h001

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SPM_CLK_NS       25
`define SPM_START_NS     1000
`define SPM_START_CYC    16'((`SPM_START_NS + `SPM_CLK_NS - 1) / `SPM_CLK_NS)
`define SPM_LAST_EDGE    4'hf

`endif

// >>> rtl/spm_pkg.sv
// Types of the SPI master: sequencer states and the full state record
package spm_pkg;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_WAKE  = 4'h1,
    ST_LEAD  = 4'h2,
    ST_FETCH = 4'h3,
    ST_SHIFT = 4'h4,
    ST_DRAIN = 4'h5,
    ST_STORE = 4'h6,
    ST_TRAIL = 4'h7,
    ST_GAP   = 4'h8
  } spm_state_t;

  typedef struct packed {
    spm_state_t  st;
    logic        ack;
    logic [31:0] rdat;
    logic [1:0]  stall;
    logic [3:0]  en;
    logic [31:0] psel_sck;
    logic [31:0] psel_mosi;
    logic [31:0] psel_miso;
    logic [31:0] chip_select_pin_select;
    logic [31:0] rate;
    logic [31:0] rx_ptr;
    logic [15:0] rx_cnt;
    logic [15:0] rx_done;
    logic [1:0]  rx_list;
    logic [31:0] tx_ptr;
    logic [15:0] tx_cnt;
    logic [15:0] tx_done;
    logic [1:0]  tx_list;
    logic [2:0]  fmt;
    logic [2:0]  rxdly;
    logic [7:0]  csndur;
    logic        pol;
    logic [31:0] dcx_psel;
    logic [3:0]  dcx_cnt;
    logic [7:0]  filler;
    logic        shorts;
    logic [2:0]  evts;
    logic [2:0]  inten;
    logic        susp;
    logic [15:0] cnt;
    logic [15:0] idx;
    logic [15:0] total;
    logic [8:0]  div;
    logic [3:0]  edge_n;
    logic [7:0]  txsh;
    logic [7:0]  rxsh;
    logic        pend;
    logic [2:0]  dcnt;
    logic        sck;
    logic        mosi;
    logic        csn;
    logic        mem_req;
    logic        mem_we;
    logic [31:0] mem_addr;
    logic [7:0]  mem_wdat;
    logic        miso_m;
    logic        miso_s;
  } spm_regs_t;

endpackage : spm_pkg

// >>> sim/spm_slave_model.sv
// SPI slave partner answering the master on MISO
`timescale 1ns/1ps
`default_nettype none
module spm_slave_model (
  // SPI pins
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       csn,
  output var  logic       miso,
  // Mode {pol,cpol,cpha,lsb} and reply base
  input  wire logic [3:0] mode,
  input  wire logic [7:0] base
);
  logic [7:0] rq[$];
  logic [7:0] sq[$];
  logic [7:0] sh = 8'h00;
  int         bi = 0;
  int         nb = 0;
  wire logic [7:0] rb = base + 8'(nb);
  wire logic       sel = (csn === mode[3]);
  initial miso = 1'b0;
  // Released line shows the inverse of its last level
  always @(sel) begin
    bi = 0;
    nb = 0;
    miso = sel ? (mode[0] ? base[0] : base[7]) : ~miso;
  end
  always @(sck) if (sel) begin
    if (sck ^ mode[2] ^ mode[1]) begin
      sh = mode[0] ? {mosi, sh[7:1]} : {sh[6:0], mosi};
      bi++;
      if (bi == 8) begin
        rq.push_back(sh);
        sq.push_back(rb);
        bi = 0;
        nb++;
      end
    end else
      miso = mode[0] ? rb[bi] : rb[7 - bi];
  end
endmodule : spm_slave_model
`default_nettype wire

// >>> sim/spm_master_checker.sv
// Port checker of the SPI master
`timescale 1ns/1ps
`default_nettype none
module spm_master_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // RAM and SPI
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic        mem_ack_i,
  input wire logic        sck_o,
  input wire logic        csn_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
  mem_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
    && $stable(mem_we_o)) else $error("ram request dropped");
  mem_release_a: assert property (mem_req_o && mem_ack_i |=> !mem_req_o) else $error("ram request kept");
  csn_gap_a: assert property ($changed(csn_o) |-> $stable(sck_o)) else $error("select on clock edge");
  sck_still_a: assert property (mem_req_o && $past(mem_req_o) |-> $stable(sck_o)) else $error("clock in ram access");
  rd_ram_c: cover property (mem_req_o && !mem_we_o && mem_ack_i);
  wr_ram_c: cover property (mem_req_o && mem_we_o && mem_ack_i);
  sel_c: cover property ($changed(csn_o));
endmodule : spm_master_checker
bind spm_master spm_master_checker i_chk (.clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
  .mem_req_o, .mem_we_o, .mem_addr_o, .mem_ack_i, .sck_o, .csn_o);
`default_nettype wire

// >>> sim/spm_master_test.sv
// Self-checking bench of the SPI master
`timescale 1ns/1ps
`default_nettype none
`include "spm_consts.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; $display("unexpected %0t %h %h", $time, g, e); end end
module spm_master_test;
  logic clk = 1'b0, rst_b = 1'b0, cs = 1'b0, we = 1'b0, mack = 1'b0, sck_q = 1'b0;
  logic miso, req, mwe, sck, mosi, csn, ack;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0, rd, rdo, mad;
  logic [7:0] mrd = 8'h00, mwd, fill, base = 8'h00;
  logic [3:0] mode = 4'h0;
  logic [7:0] mem [int];
  logic [7:0] exq[$];
  int n_fail = 0, checked = 0, wt = 1, run = 0, hp = 0, nr, nwr, n, tc, rc, tp, rp;
  int hv[9] = '{160, 80, 40, 20, 10, 5, 2, 1, 1};
  logic [31:0] rv[9] = '{`SPM_R_K125, `SPM_R_K250, `SPM_R_K500, `SPM_R_M1, `SPM_R_M2, `SPM_R_M4, `SPM_R_M8,
    `SPM_R_M16, `SPM_R_M32};
  spm_master i_dut (.clk, .rst_b, .wb_cyc_i(cs), .wb_stb_i(cs), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hf), .wb_dat_o(rdo), .wb_ack_o(ack), .mem_req_o(req), .mem_we_o(mwe), .mem_addr_o(mad),
    .mem_wdata_o(mwd), .mem_rdata_i(mrd), .mem_ack_i(mack), .sck_o(sck), .mosi_o(mosi), .miso_i(miso), .csn_o(csn));
  spm_slave_model i_slave (.sck, .mosi, .csn, .miso, .mode, .base);
  always #12.5 clk = ~clk;
  // RAM answering after two to four cycles
  always @(posedge clk) begin
    mack <= 1'b0;
    sck_q <= sck;
    run <= (sck !== sck_q) ? 1 : run + 1;
    if (sck !== sck_q)
      hp <= run;
    if (req && !mack) begin
      if (wt == 0) begin
        mack <= 1'b1;
        wt <= $urandom_range(3, 1);
        if (mwe) begin
          mem[int'(mad)] = mwd;
          nwr++;
        end else begin
          mrd <= mem[int'(mad)];
          nr++;
        end
      end else
        wt <= wt - 1;
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge clk);
    cs <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rd = rdo;
    cs <= 1'b0;
    if (k >= 20) begin
      n_fail++;
      finish_test();
    end
  endtask : wb
  initial begin
    void'($urandom(24025));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    wb(0, `SPM_A_RATE, 0);
    `CHK(rd, `SPM_RATE_RST)
    wb(0, 12'h7fc, 0);
    `CHK(rd, 32'h0)
    wb(1, `SPM_A_INTENSET, 32'h7);
    wb(1, `SPM_A_IRQ_DISABLE_REG, 32'h2);
    wb(0, `SPM_A_INTENSET, 0);
    `CHK(rd, 32'h5)
    wb(1, `SPM_A_ENABLE, 32'h7);
    for (int i = 0; i < 9; i++) begin
      mode = 4'(i * 5);
      tc = $urandom_range(3, 1);
      rc = (i == 0) ? 3 : $urandom_range(3, 0);
      tp = 32'h1000 * (i + 1);
      rp = tp + 32'h800;
      base = 8'($urandom);
      fill = 8'($urandom);
      exq = {};
      for (int k = 0; k < 3; k++)
        mem[tp + k] = 8'($urandom);
      for (int k = 0; k < (tc > rc ? tc : rc); k++)
        exq.push_back(k < tc ? mem[tp + k] : fill);
      wb(1, `SPM_A_RATE, rv[i]);
      wb(1, `SPM_A_FORMAT, 32'(mode[2:0]));
      wb(1, `SPM_A_SELECT_POLARITY, 32'(mode[3]));
      wb(1, `SPM_A_TX_PTR, tp);
      wb(1, `SPM_A_TX_CNT, tc);
      wb(1, `SPM_A_TX_LIST, i & 1);
      wb(1, `SPM_A_RX_PTR, rp);
      wb(1, `SPM_A_RX_CNT, rc);
      wb(1, `SPM_A_RX_LIST, i & 1);
      wb(1, `SPM_A_RXDELAY, hv[i] >= 5 ? i & 3 : 0);
      wb(1, `SPM_A_CSNDUR, 20 * i);
      wb(1, `SPM_A_FILLER, fill);
      wb(0, `SPM_A_RATE, 0);
      `CHK(rd, rv[i])
      `CHK(sck, mode[2])
      `CHK(csn, !mode[3])
      nr = 0;
      nwr = 0;
      i_slave.rq = {};
      i_slave.sq = {};
      wb(1, `SPM_A_START, 1);
      for (n = 0; csn !== mode[3] && n < 200; n++)
        @(posedge clk);
      `CHK(n > 35 && n < 46, 1'b1)
      if (n == 200)
        finish_test();
      if (i == 2) begin
        wb(1, `SPM_A_SUSPEND, 1);
        repeat (300) @(posedge clk);
        `CHK(nr, 0)
        wb(1, `SPM_A_RESUME, 1);
      end
      for (n = 0; sck === mode[2] && n < 400; n++)
        @(posedge clk);
      `CHK(n > 20 * i && n < 400, 1'b1)
      if (n == 400)
        finish_test();
      rd = 0;
      for (n = 0; rd[0] !== 1'b1 && n < 5000; n++)
        wb(0, `SPM_A_EV_END, 0);
      `CHK(rd[0], 1'b1)
      if (n == 5000)
        finish_test();
      wb(1, `SPM_A_EV_END, 0);
      `CHK(i_slave.rq.size(), exq.size())
      foreach (exq[k]) `CHK(i_slave.rq[k], exq[k])
      for (int k = 0; k < rc && hv[i] >= 5; k++) `CHK(mem[rp + k], i_slave.sq[k])
      `CHK(nr, tc)
      `CHK(nwr, rc)
      `CHK(hp, hv[i])
      wb(0, `SPM_A_TX_DONE, 0);
      `CHK(rd, 32'(tc))
      wb(0, `SPM_A_RX_DONE, 0);
      `CHK(rd, 32'(rc))
      wb(0, `SPM_A_TX_PTR, 0);
      `CHK(rd, 32'(tp + (i & 1) * tc))
      wb(0, `SPM_A_RX_PTR, 0);
      `CHK(rd, 32'(rp + (i & 1) * rc))
    end
    wb(1, `SPM_A_SHORTS, 1);
    wb(1, `SPM_A_START, 1);
    for (n = 0; csn !== mode[3] && n < 200; n++)
      @(posedge clk);
    for (tc = 0; csn === mode[3] && tc < 2000; tc++)
      @(posedge clk);
    `CHK(n < 200 && tc < 2000, 1'b1)
    if (n == 200 || tc == 2000)
      finish_test();
    for (n = 0; csn !== mode[3] && n < 400; n++)
      @(posedge clk);
    `CHK(n > 160 && n < 400, 1'b1)
    if (n == 400)
      finish_test();
    wb(1, `SPM_A_STOP, 1);
    `CHK(csn, !mode[3])
    wb(0, `SPM_A_STALL, 0);
    `CHK(rd, 32'h3)
    wb(1, `SPM_A_STALL, 32'h1);
    wb(0, `SPM_A_STALL, 0);
    `CHK(rd, 32'h1)
    finish_test();
  end
endmodule : spm_master_test
`default_nettype wire
